// file: core/srp_pkg.sv
////////////////////////////////////////////////////////////////////////////
// shared constants, types and helpers of the register pointer block
package srp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths and selection codes
    localparam int         SRP_PTR_W       = 8;      // pointer byte width
    localparam logic [1:0] SRP_SEL_TEMP    = 2'h0;   // temperature result
    localparam logic [1:0] SRP_SEL_CFG     = 2'h1;   // configuration
    localparam logic [1:0] SRP_SEL_LOW     = 2'h2;   // low limit
    localparam logic [1:0] SRP_SEL_HIGH    = 2'h3;   // high limit

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0]  SRP_PTR_RESET   = 8'h00;    // temperature first
    localparam logic [7:0]  SRP_CFG_RESET   = 8'h00;    // all bits clear
    localparam logic [11:0] SRP_TEMP_RESET  = 12'h000;  // zero degrees
    localparam logic [15:0] SRP_LIMIT_RESET = 16'h0000; // plain default
    localparam logic [3:0]  SRP_LSB_PAD     = 4'h0;     // unused temp bits

    ////////////////////////////////////////////////////////////////////////
    // two-wire framing
    localparam logic [6:0] SRP_TARGET_ADDR_DEF = 7'h2a; // arbitrary value
    localparam logic [3:0] SRP_BITS_PER_BYTE   = 4'h8;  // bits in a byte
    localparam logic [3:0] SRP_CNT_ZERO        = 4'h0;  // counter start
    localparam logic [3:0] SRP_CNT_ONE         = 4'h1;  // counter step
    localparam logic       SRP_ACK_LEVEL       = 1'b0;  // low means ack
    localparam logic       SRP_RW_READ         = 1'b1;  // direction bit
    localparam logic [1:0] SRP_WR_FIRST        = 2'h0;  // first data byte
    localparam logic [1:0] SRP_WR_SECOND       = 2'h1;  // second data byte
    localparam logic [1:0] SRP_WR_DONE         = 2'h2;  // extra bytes

    ////////////////////////////////////////////////////////////////////////
    // target state machine, one-hot
    typedef enum logic [6:0] {
        SRP_IDLE     = 7'h01,
        SRP_ADDR     = 7'h02,
        SRP_ADDR_ACK = 7'h04,
        SRP_WR_BYTE  = 7'h08,
        SRP_WR_ACK   = 7'h10,
        SRP_RD_BYTE  = 7'h20,
        SRP_RD_ACK   = 7'h40
    } srp_state_t;

    // writable data registers as seen by the sensor core
    typedef struct packed {
        logic [7:0]  cfg;   // configuration
        logic [15:0] low;   // low limit
        logic [15:0] high;  // high limit
    } srp_regs_t;

    ////////////////////////////////////////////////////////////////////////
    // only the two low pointer bits choose a register
    function automatic logic [1:0] srp_sel(input logic [7:0] ptr);
        return ptr[1:0];
    endfunction

    // pick the most significant byte first, then the low byte
    function automatic logic [7:0] srp_pick(input logic [15:0] word,
                                            input logic        half);
        return half ? word[7:0] : word[15:8];
    endfunction

endpackage

// file: core/srp_reg_store.sv
////////////////////////////////////////////////////////////////////////////
// data registers behind the pointer, with a registered read byte
module srp_reg_store
    import srp_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        wrEn,      // a data byte arrived
    input  wire logic [1:0]  wrSel,     // pointer selection
    input  wire logic [1:0]  wrIdx,     // data byte index in the frame
    input  wire logic [7:0]  wrData,    // the byte itself
    input  wire logic        tempLoad,  // conversion finished
    input  wire logic [11:0] tempCode,  // new conversion result
    input  wire logic [1:0]  rdSel,     // pointer selection
    input  wire logic        rdHalf,    // 0 upper byte, 1 lower byte
    output logic      [7:0]  rdData,    // byte for the shifter
    output srp_regs_t        regs       // writable registers
);

    logic [11:0] tempReg;   // latest conversion result

    ////////////////////////////////////////////////////////////////////////
    // write decode; the temperature code has no write strobe at all
    wire cfgWr    = wrEn & (wrSel == SRP_SEL_CFG)
                  & (wrIdx == SRP_WR_FIRST);
    wire lowHiWr  = wrEn & (wrSel == SRP_SEL_LOW)
                  & (wrIdx == SRP_WR_FIRST);
    wire lowLoWr  = wrEn & (wrSel == SRP_SEL_LOW)
                  & (wrIdx == SRP_WR_SECOND);
    wire highHiWr = wrEn & (wrSel == SRP_SEL_HIGH)
                  & (wrIdx == SRP_WR_FIRST);
    wire highLoWr = wrEn & (wrSel == SRP_SEL_HIGH)
                  & (wrIdx == SRP_WR_SECOND);

    // temperature as a left-aligned word, low nibble padded with zeros
    wire [15:0] tempWord = {tempReg, SRP_LSB_PAD};

    // read selection
    wire [7:0] next_rdData =
        (rdSel == SRP_SEL_TEMP) ? srp_pick(tempWord, rdHalf) :
        (rdSel == SRP_SEL_CFG)  ? regs.cfg :
        (rdSel == SRP_SEL_LOW)  ? srp_pick(regs.low, rdHalf) :
                                  srp_pick(regs.high, rdHalf);

    ////////////////////////////////////////////////////////////////////////
    // temperature result: zero until the first conversion lands
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            tempReg <= SRP_TEMP_RESET;
        else if (tempLoad)
            tempReg <= tempCode;
    end

    // configuration and limits, most significant byte first
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            regs.cfg  <= SRP_CFG_RESET;
            regs.low  <= SRP_LIMIT_RESET;
            regs.high <= SRP_LIMIT_RESET;
        end
        else
        begin
            if (cfgWr)
                regs.cfg <= wrData;
            if (lowHiWr)
                regs.low[15:8] <= wrData;
            if (lowLoWr)
                regs.low[7:0] <= wrData;
            if (highHiWr)
                regs.high[15:8] <= wrData;
            if (highLoWr)
                regs.high[7:0] <= wrData;
        end
    end

    // read byte is registered; the bus clock is far slower than clk_sys
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rdData <= SRP_PTR_RESET;
        else
            rdData <= next_rdData;
    end

endmodule // srp_reg_store

// file: core/srp_sensor_register_pointer.sv
////////////////////////////////////////////////////////////////////////////
// two-wire target with the register pointer of the temperature sensor

module srp_sensor_register_pointer
    import srp_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = SRP_TARGET_ADDR_DEF // arbitrary
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        sclIn,     // bus clock line level
    input  wire logic        sdaIn,     // bus data line level
    output logic             sdaOut,    // level driven when enabled
    output logic             sdaOe,     // high while pulling data low
    input  wire logic        tempLoad,  // converter result strobe
    input  wire logic [11:0] tempCode,  // converter result
    output logic      [7:0]  pointer,   // pointer register
    output srp_regs_t        regs       // writable registers
);

    ////////////////////////////////////////////////////////////////////////
    // line synchronisers and filtered levels
    logic sclS1, sclS2, sclS3;  // clock line stages
    logic sdaS1, sdaS2, sdaS3;  // data line stages
    logic sclF, sdaF;           // accepted levels
    logic sclPrev, sdaPrev;     // previous accepted levels

    // frame state
    srp_state_t  state;         // target state
    logic [3:0]  bitCnt;        // bits moved in this byte
    logic [7:0]  shiftReg;      // byte in or out
    logic        rwBit;         // direction of this transfer
    logic        firstByte;     // next written byte is the pointer
    logic [1:0]  wrIdx;         // data byte index of a write
    logic        rdHalf;        // which byte of a read goes next
    logic        rdAcked;       // controller asked for more

    logic [7:0]  rdData;        // byte offered by the register store

    ////////////////////////////////////////////////////////////////////////
    // events on the filtered lines
    wire sclRise   = sclF & ~sclPrev;
    wire sclFall   = ~sclF & sclPrev;
    wire startSeen = sclF & sclPrev & sdaPrev & ~sdaF;
    wire stopSeen  = sclF & sclPrev & ~sdaPrev & sdaF;
    wire byteDone  = (bitCnt == SRP_BITS_PER_BYTE);
    wire addrMatch = (shiftReg[7:1] == TARGET_ADDR);
    wire [3:0] cntInc = bitCnt + SRP_CNT_ONE;
    wire [7:0] shiftIn = {shiftReg[6:0], sdaF};

    // a written byte at the end of its eighth bit
    wire byteIn   = (state == SRP_WR_BYTE) & sclFall & byteDone;
    wire ptrWr    = byteIn & firstByte;
    // bytes after the pointer; the store drops those aimed at temperature
    wire dataWr   = byteIn & ~firstByte;
    wire [1:0] curSel = srp_sel(pointer);

    ////////////////////////////////////////////////////////////////////////
    // three stages; a change counts once stages two and three agree
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sclS1 <= 1'b1;
            sclS2 <= 1'b1;
            sclS3 <= 1'b1;
            sdaS1 <= 1'b1;
            sdaS2 <= 1'b1;
            sdaS3 <= 1'b1;
        end
        else
        begin
            sclS1 <= sclIn;
            sclS2 <= sclS1;
            sclS3 <= sclS2;
            sdaS1 <= sdaIn;
            sdaS2 <= sdaS1;
            sdaS3 <= sdaS2;
        end
    end

    // accepted levels hold through single-cycle glitches
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sclF    <= 1'b1;
            sdaF    <= 1'b1;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end
        else
        begin
            if (sclS2 == sclS3)
                sclF <= sclS3;
            if (sdaS2 == sdaS3)
                sdaF <= sdaS3;
            sclPrev <= sclF;
            sdaPrev <= sdaF;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pointer: the whole byte is kept, selection looks at two bits only
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            pointer <= SRP_PTR_RESET;
        else if (ptrWr)
            pointer <= shiftReg;
    end

    // open-drain data line: the driven level is always low
    always_ff @(posedge clk_sys)
    begin
        sdaOut <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // target sequencer; start and stop win in any state so a confused
    // frame always recovers at the next start condition
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state     <= SRP_IDLE;
            bitCnt    <= SRP_CNT_ZERO;
            shiftReg  <= SRP_PTR_RESET;
            sdaOe     <= 1'b0;
            rwBit     <= 1'b0;
            firstByte <= 1'b0;
            wrIdx     <= SRP_WR_FIRST;
            rdHalf    <= 1'b0;
            rdAcked   <= 1'b0;
        end
        else if (startSeen)
        begin
            // repeated start keeps the pointer; only framing restarts
            state  <= SRP_ADDR;
            bitCnt <= SRP_CNT_ZERO;
            sdaOe  <= 1'b0;
        end
        else if (stopSeen)
        begin
            state <= SRP_IDLE;
            sdaOe <= 1'b0;
        end
        else
        begin
            unique case (state)
                SRP_IDLE:
                begin
                    sdaOe <= 1'b0;
                end
                SRP_ADDR:
                begin
                    // collect address and direction
                    if (sclRise)
                    begin
                        shiftReg <= shiftIn;
                        bitCnt   <= cntInc;
                    end
                    else if (sclFall && byteDone)
                    begin
                        if (addrMatch)
                        begin
                            sdaOe  <= 1'b1;
                            rwBit  <= shiftReg[0];
                            rdHalf <= 1'b0;
                            state  <= SRP_ADDR_ACK;
                        end
                        else
                            state <= SRP_IDLE;
                    end
                end
                SRP_ADDR_ACK:
                begin
                    // after the ack, read from the current pointer or
                    // expect a fresh pointer byte
                    if (sclFall)
                    begin
                        bitCnt <= SRP_CNT_ZERO;
                        if (rwBit == SRP_RW_READ)
                        begin
                            shiftReg <= rdData;
                            sdaOe    <= ~rdData[7];
                            state    <= SRP_RD_BYTE;
                        end
                        else
                        begin
                            sdaOe     <= 1'b0;
                            firstByte <= 1'b1;
                            wrIdx     <= SRP_WR_FIRST;
                            state     <= SRP_WR_BYTE;
                        end
                    end
                end
                SRP_WR_BYTE:
                begin
                    if (sclRise)
                    begin
                        shiftReg <= shiftIn;
                        bitCnt   <= cntInc;
                    end
                    else if (byteIn)
                    begin
                        // every byte is acked, dropped ones included
                        sdaOe     <= 1'b1;
                        firstByte <= 1'b0;
                        if (!firstByte && wrIdx != SRP_WR_DONE)
                            wrIdx <= wrIdx + SRP_WR_SECOND;
                        state <= SRP_WR_ACK;
                    end
                end
                SRP_WR_ACK:
                begin
                    if (sclFall)
                    begin
                        sdaOe  <= 1'b0;
                        bitCnt <= SRP_CNT_ZERO;
                        state  <= SRP_WR_BYTE;
                    end
                end
                SRP_RD_BYTE:
                begin
                    // shift out most significant bit first
                    if (sclRise)
                        bitCnt <= cntInc;
                    else if (sclFall)
                    begin
                        if (byteDone)
                        begin
                            sdaOe  <= 1'b0;
                            rdHalf <= ~rdHalf;
                            state  <= SRP_RD_ACK;
                        end
                        else
                        begin
                            shiftReg <= {shiftReg[6:0], 1'b0};
                            sdaOe    <= ~shiftReg[6];
                        end
                    end
                end
                SRP_RD_ACK:
                begin
                    // a nack ends the read; the line stays released
                    if (sclRise)
                        rdAcked <= (sdaF == SRP_ACK_LEVEL);
                    else if (sclFall)
                    begin
                        bitCnt <= SRP_CNT_ZERO;
                        if (rdAcked)
                        begin
                            shiftReg <= rdData;
                            sdaOe    <= ~rdData[7];
                            state    <= SRP_RD_BYTE;
                        end
                        else
                            state <= SRP_IDLE;
                    end
                end
                default:
                begin
                    state <= SRP_IDLE;
                    sdaOe <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data registers selected by the pointer
    srp_reg_store u_store (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .wrEn     (dataWr),
        .wrSel    (curSel),
        .wrIdx    (wrIdx),
        .wrData   (shiftReg),
        .tempLoad (tempLoad),
        .tempCode (tempCode),
        .rdSel    (curSel),
        .rdHalf   (rdHalf),
        .rdData   (rdData),
        .regs     (regs)
    );

endmodule // srp_sensor_register_pointer

// file: tb/srp_sensor_register_pointer_monitor.sv
////////////////////////////////////////////////////////////////////////////
// port-level checker of the register pointer target
module srp_sensor_register_pointer_monitor
    import srp_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        sclIn,
    input wire logic        sdaIn,
    input wire logic        sdaOut,
    input wire logic        sdaOe,
    input wire logic        tempLoad,
    input wire logic [11:0] tempCode,
    input wire logic [7:0]  pointer,
    input wire srp_regs_t   regs
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // reset values, watched through the reset itself
    property p_rst_ptr;
        disable iff (1'b0) rst |=> pointer == SRP_PTR_RESET;
    endproperty
    a_rst_ptr: assert property (p_rst_ptr)
        else $error("pointer reset");
    property p_rst_regs;
        disable iff (1'b0) rst |=> regs.cfg == SRP_CFG_RESET;
    endproperty
    a_rst_regs: assert property (p_rst_regs)
        else $error("cfg reset");

    ////////////////////////////////////////////////////////////////////////
    // open drain data line: only pulls low, starts pulling while clock low
    property p_od_level; sdaOut == 1'b0; endproperty
    a_od_level: assert property (p_od_level)
        else $error("sda high");
    property p_oe_rise; $rose(sdaOe) |-> !sclIn; endproperty
    a_oe_rise: assert property (p_oe_rise)
        else $error("oe rise");
    property p_oe_hold; $rose(sdaOe) |=> sdaOe [*8]; endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("oe short");
    property p_ptr_time; !$stable(pointer) |-> !sclIn; endproperty
    a_ptr_time: assert property (p_ptr_time)
        else $error("ptr time");

    ////////////////////////////////////////////////////////////////////////
    // a writable register only moves while the pointer selects it
    property p_temp_drop;
        $stable(pointer) && pointer[1:0] == SRP_SEL_TEMP |-> $stable(regs);
    endproperty
    a_temp_drop: assert property (p_temp_drop)
        else $error("temp wr");
    property p_cfg_sel;
        pointer[1:0] != SRP_SEL_CFG |-> $stable(regs.cfg);
    endproperty
    a_cfg_sel: assert property (p_cfg_sel)
        else $error("cfg sel");
    property p_low_sel;
        pointer[1:0] != SRP_SEL_LOW |-> $stable(regs.low);
    endproperty
    a_low_sel: assert property (p_low_sel)
        else $error("low sel");
    property p_high_sel;
        pointer[1:0] != SRP_SEL_HIGH |-> $stable(regs.high);
    endproperty
    a_high_sel: assert property (p_high_sel)
        else $error("high sel");

    c_cfg: cover property (!$stable(regs.cfg));
    c_ack: cover property ($rose(sdaOe));
    c_high: cover property (pointer[1:0] == SRP_SEL_HIGH);
endmodule // srp_sensor_register_pointer_monitor

bind srp_sensor_register_pointer srp_sensor_register_pointer_monitor i_mon
(
    .clk_sys(clk_sys), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .tempLoad(tempLoad),
    .tempCode(tempCode), .pointer(pointer), .regs(regs)
);

// file: tb/srp_bus_host.sv
////////////////////////////////////////////////////////////////////////////
// bus controller model: bit-banged two-wire host
module srp_bus_host
(
    input  wire logic clk_sys,  // system clock
    input  wire logic sdaLine,  // wired data line level
    output logic      scl,      // clock line, only the host drives it
    output logic      sdaPull   // high while the host pulls data low
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        scl = 1'b1;      // idle bus, clock stands still between frames
        sdaPull = 1'b0;  // released, the pull-up wins
    end

    // each phase 10 clk, so slow targets see every level settle
    task automatic hold();
        repeat (10) @(posedge clk_sys);
        #1;
    endtask

    // start or repeated start: data falls while clock is high
    task automatic start();
        sdaPull = 1'b0;
        hold();
        scl = 1'b1;
        hold();
        sdaPull = 1'b1;
        hold();
        scl = 1'b0;
        hold();
    endtask

    // stop: data rises while clock is high
    task automatic stop();
        sdaPull = 1'b1;
        hold();
        scl = 1'b1;
        hold();
        sdaPull = 1'b0;
        hold();
    endtask

    // data set while clock low, sampled at the end of the high phase
    task automatic bit_io(input logic b, output logic s);
        sdaPull = ~b;
        hold();
        scl = 1'b1;
        hold();
        s = sdaLine;
        scl = 1'b0;
        hold();
    endtask

    // byte out msb first, then the target acknowledge slot
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, ack);
    endtask

    // byte in msb first, then our acknowledge (0) or refusal (1)
    task automatic get_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(nack, s);
    endtask
endmodule // srp_bus_host

// file: tb/tb_sensor_register_pointer.sv
////////////////////////////////////////////////////////////////////////////
// self-checking bench of the register pointer target
module tb_sensor_register_pointer;
    timeunit 1ns;
    timeprecision 1ps;
    import srp_pkg::*;

    typedef struct packed {
        logic [7:0] ptr, d1, d2;  // pointer byte and data bytes
        logic [1:0] n;            // data bytes sent
        logic [7:0] r1, r2;       // two bytes read back
    } srp_row_t;

    logic        clk_sys = 1'b0;
    logic        rst, tempLoad, sdaOut, sdaOe, scl, sdaPull, ack;
    logic [11:0] tempCode;
    logic [7:0]  pointer, r1, r2;
    srp_regs_t   regs;
    int          errors = 0;
    int          nTests = 0;
    wire         sdaLine = ~(sdaPull | (sdaOe & ~sdaOut)); // pull-up

    // row 3 breaks the upper-bits-zero habit on purpose
    srp_row_t rows [5] = '{
        '{8'h01, 8'h60, 8'h00, 2'h1, 8'h60, 8'h60},
        '{8'h02, 8'h12, 8'h34, 2'h2, 8'h12, 8'h34},
        '{8'h03, 8'hab, 8'hcd, 2'h2, 8'hab, 8'hcd},
        '{8'h42, 8'h9e, 8'h00, 2'h1, 8'h9e, 8'h34},
        '{8'h00, 8'h77, 8'h88, 2'h2, 8'hff, 8'hc0}};

    always #10 clk_sys = ~clk_sys;

    srp_sensor_register_pointer i_dut (.clk_sys(clk_sys), .rst(rst),
        .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .tempLoad(tempLoad), .tempCode(tempCode), .pointer(pointer),
        .regs(regs));
    srp_bus_host i_host (.clk_sys(clk_sys), .sdaLine(sdaLine), .scl(scl),
        .sdaPull(sdaPull));

    ////////////////////////////////////////////////////////////////////////
    // compares and verdict
    task automatic chk_val(input logic [39:0] got, input logic [39:0] exp);
        nTests++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_ack(input logic got, input logic exp);
        nTests++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: ack %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // frames; ack comes back 0 only if the target acknowledged every byte sent to it
    task automatic wr_frame(input srp_row_t r, output logic a);
        logic a0, a1, a2, a3;
        a2 = 1'b0;
        a3 = 1'b0;
        i_host.start();
        i_host.put_byte({SRP_TARGET_ADDR_DEF, 1'b0}, a0);
        i_host.put_byte(r.ptr, a1);
        if (r.n > 2'h0)
            i_host.put_byte(r.d1, a2);
        if (r.n > 2'h1)
            i_host.put_byte(r.d2, a3);
        i_host.stop();
        a = a0 | a1 | a2 | a3;
    endtask

    task automatic rd_frame(output logic a, output logic [7:0] b1, b2);
        i_host.start();
        i_host.put_byte({SRP_TARGET_ADDR_DEF, 1'b1}, a);
        i_host.get_byte(1'b0, b1);
        i_host.get_byte(1'b1, b2);
        i_host.stop();
    endtask

    // reset, then reset values and a read with no pointer write
    task automatic do_reset();
        rst = 1'b1;
        repeat (16) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        chk_val(pointer, 40'h0);
        chk_val(regs, 40'h0);
        rd_frame(ack, r1, r2);
        chk_ack(ack, 1'b0);
        chk_val({r1, r2}, 40'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        rst = 1'b1;
        tempLoad = 1'b0;
        tempCode = 12'h000;
        do_reset();
        @(posedge clk_sys);
        #1;
        tempCode = 12'hffc;  // minus a quarter degree
        tempLoad = 1'b1;
        @(posedge clk_sys);
        #1;
        tempLoad = 1'b0;
        foreach (rows[i])
        begin
            wr_frame(rows[i], ack);
            chk_ack(ack, 1'b0);
            chk_val(pointer, rows[i].ptr);
            rd_frame(ack, r1, r2);
            chk_val({r1, r2}, {rows[i].r1, rows[i].r2});
        end
        chk_val(regs, {8'h60, 16'h9e34, 16'habcd});
        // pointer set, then a repeated start with no stop, then a read;
        // this also leaves a non-zero pointer for the mid-run reset
        i_host.start();
        i_host.put_byte({SRP_TARGET_ADDR_DEF, 1'b0}, ack);
        i_host.put_byte(8'h02, ack);
        chk_ack(ack, 1'b0);
        rd_frame(ack, r1, r2);
        chk_ack(ack, 1'b0);
        chk_val({r1, r2}, {8'h9e, 8'h34});
        // a foreign address must stay unanswered
        i_host.start();
        i_host.put_byte({SRP_TARGET_ADDR_DEF ^ 7'h01, 1'b0}, ack);
        i_host.stop();
        chk_ack(ack, 1'b1);
        do_reset();  // second reset in mid-run
        report_and_stop();
    end

    // watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        report_and_stop();
    end
endmodule // tb_sensor_register_pointer
